// >>> bsram_pkg.sv
// Shared constants and types for the burst-of-two synchronous SRAM core.
// Assumes a single 25 MHz system clock that oversamples the memory pins.
package bsram_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int WR_W = ADDR_W + DATA_W;
  localparam int CLK_PERIOD_NS = 40;
  localparam int K_STOP_NS = 30;
  localparam int K_STOP_CYC = (K_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYCLES = 2048;
  localparam int LOCK_W = 12;
  localparam int STOP_W = 8;
  localparam int WR_DELAY = 4;
  localparam int PIN_W = 5;
  // Bit positions inside the synchronised clock/control pin vector
  localparam int PIN_K = 0;
  localparam int PIN_KN = 1;
  localparam int PIN_C = 2;
  localparam int PIN_CN = 3;
  localparam int PIN_OFF = 4;
  localparam logic [LOCK_W-1:0] LOCK_RST = 12'h000;
  localparam logic [STOP_W-1:0] STOP_RST = 8'h00;
  localparam logic [DATA_W-1:0] DQ_RST = 18'h00000;
  // Cycles after reset until the third pin flop holds a real sample
  localparam logic [1:0] WARM_DONE = 2'h3;

  typedef enum logic [2:0] {
    OUT_IDLE,
    OUT_ARM,
    OUT_BEAT1,
    OUT_BEAT2,
    OUT_TAIL
  } bsram_out_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bsram_wr_s;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } bsram_cmd_s;

  typedef struct packed {
    logic [PIN_W-1:0] p_s1;
    logic [PIN_W-1:0] p_s2;
    logic [PIN_W-1:0] p_s3;
    logic [1:0] warm;
    logic ld_s1;
    logic ld_s2;
    logic rw_s1;
    logic rw_s2;
    logic [ADDR_W-1:0] addr_s1;
    logic [ADDR_W-1:0] addr_s2;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [STOP_W-1:0] stop_k;
    logic [STOP_W-1:0] stop_kn;
    logic [LOCK_W-1:0] lock_cnt;
    logic ready;
    logic locked;
    bsram_cmd_s [WR_DELAY-1:0] wr_pipe;
    logic wr_b2;
    logic [ADDR_W-1:0] wr_addr;
    logic [1:0] fetch;
    logic [ADDR_W-1:0] fetch_addr;
    logic slot_valid;
    logic [DATA_W-1:0] slot_b1;
    logic [DATA_W-1:0] slot_b2;
    bsram_out_e ostate;
    logic [DATA_W-1:0] act_b1;
    logic [DATA_W-1:0] act_b2;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
    logic overrun;
  } bsram_state_s;
endpackage : bsram_pkg

// >>> bsram_store.sv
// Write-data FIFO and the single-port storage array of the SRAM core.
// Both run on the system clock; the core arbitrates the array port.
`timescale 1ns/1ps
`default_nettype none
module bsram_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } bsram_fifo_s;
  bsram_fifo_s st;
  bsram_fifo_s next_st;
  logic [W-1:0] store [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = (st.cnt != (PW+1)'(DEPTH));
  assign out_valid_out = (st.cnt != '0);
  assign out_data_out = store[st.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb
  begin
    next_st = st;
    if (push)
      next_st.wp = st.wp + PW'(1);
    if (pop)
      next_st.rp = st.rp + PW'(1);
    if (push && !pop)
      next_st.cnt = st.cnt + (PW+1)'(1);
    else if (pop && !push)
      next_st.cnt = st.cnt - (PW+1)'(1);
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st <= '0;
    else
      st <= next_st;
  end

  // Storage has no reset; only entries counted as valid are ever read
  always_ff @(posedge clk_in)
  begin
    if (push)
      store[st.wp] <= in_data_in;
  end
endmodule : bsram_fifo

module bsram_mem #(
  parameter int AW = 8,
  parameter int DW = 18
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge clk_in)
  begin
    if (en_in && we_in)
      cells[addr_in] <= wdata_in;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_out <= '0;
    else if (en_in && !we_in)
      rdata_out <= cells[addr_in];
  end
endmodule : bsram_mem
`default_nettype wire

// >>> bsram_core.sv
// Command decode, burst sequencing and loop-lock start-up of the SRAM.
// Memory pins are oversampled: every pin passes two flops on clk_in, and
// the memory clocks must toggle well below the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module bsram_core
  import bsram_pkg::*;
#(
  parameter int STOP_CYCLES = K_STOP_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic k_in,
  input wire logic k_n_in,
  input wire logic c_in,
  input wire logic c_n_in,
  input wire logic dll_off_n_in,
  input wire logic load_strobe_n_in,
  input wire logic rw_sel_in,
  input wire logic [bsram_pkg::ADDR_W-1:0] addr_in,
  input wire logic [bsram_pkg::DATA_W-1:0] dq_in,
  output logic [bsram_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic ready_out,
  output logic dll_locked_out,
  output logic overrun_out
);
  import bsram_pkg::*;

  bsram_state_s st;
  bsram_state_s next_st;
  logic k_rise, kn_rise, c_rise, cn_rise, off_rise;
  logic single_clk, true_edge, comp_edge, b1_edge, b2_edge;
  logic stop_hit, dll_reset, cmd_rd, cmd_wr, beat1, beat2;
  logic burst_low_address_bit;
  logic primed;
  logic mem_rd, mem_en;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] mem_rdata;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  bsram_wr_s fifo_in, fifo_out;

  // A pin parked high through reset must not count as a rise afterwards
  assign primed = (st.warm == WARM_DONE);
  assign k_rise = primed & st.p_s2[PIN_K] & ~st.p_s3[PIN_K];
  assign kn_rise = primed & st.p_s2[PIN_KN] & ~st.p_s3[PIN_KN];
  assign c_rise = primed & st.p_s2[PIN_C] & ~st.p_s3[PIN_C];
  assign cn_rise = primed & st.p_s2[PIN_CN] & ~st.p_s3[PIN_CN];
  assign off_rise = primed & st.p_s2[PIN_OFF] & ~st.p_s3[PIN_OFF];
  // Output clocks both parked high hand read timing to the input pair
  assign single_clk = st.p_s2[PIN_C] & st.p_s2[PIN_CN];
  assign true_edge = single_clk ? k_rise : c_rise;
  assign comp_edge = single_clk ? kn_rise : cn_rise;
  // Locked loop: beats at t+1.5 / t+2; loop off: half a cycle earlier
  assign b1_edge = st.locked ? comp_edge : true_edge;
  assign b2_edge = st.locked ? true_edge : comp_edge;
  assign stop_hit = (st.stop_k == STOP_W'(STOP_CYCLES - 1)
                     && st.p_s2[PIN_K] == st.p_s3[PIN_K])
                 || (st.stop_kn == STOP_W'(STOP_CYCLES - 1)
                     && st.p_s2[PIN_KN] == st.p_s3[PIN_KN]);
  assign dll_reset = stop_hit | off_rise;
  assign cmd_rd = k_rise & st.ready & ~st.ld_s2 & st.rw_s2;
  assign cmd_wr = k_rise & st.ready & ~st.ld_s2 & ~st.rw_s2;
  assign beat1 = k_rise & st.wr_pipe[WR_DELAY-1].valid;
  assign beat2 = kn_rise & st.wr_b2;
  assign burst_low_address_bit = ~st.fetch_addr[0];
  assign mem_rd = cmd_rd | (st.fetch == 2'h1);
  assign mem_en = mem_rd | fifo_out_valid;
  assign mem_addr = cmd_rd ? st.addr_s2
                  : mem_rd ? {st.fetch_addr[ADDR_W-1:1], burst_low_address_bit}
                  : fifo_out.addr;
  assign fifo_in_valid = beat1 | beat2;
  assign fifo_in.addr = beat1 ? st.wr_pipe[WR_DELAY-1].addr
                      : {st.wr_addr[ADDR_W-1:1], ~st.wr_addr[0]};
  assign fifo_in.data = st.dq_s2;

  always_comb
  begin
    next_st = st;
    next_st.p_s1 = {dll_off_n_in, c_n_in, c_in, k_n_in, k_in};
    next_st.p_s2 = st.p_s1;
    next_st.p_s3 = st.p_s2;
    if (st.warm != WARM_DONE)
      next_st.warm = st.warm + 2'h1;
    next_st.ld_s1 = load_strobe_n_in;
    next_st.ld_s2 = st.ld_s1;
    next_st.rw_s1 = rw_sel_in;
    next_st.rw_s2 = st.rw_s1;
    next_st.addr_s1 = addr_in;
    next_st.addr_s2 = st.addr_s1;
    next_st.dq_s1 = dq_in;
    next_st.dq_s2 = st.dq_s1;
    // Static-clock watch, saturating so one stop gives one reset
    if (st.p_s2[PIN_K] != st.p_s3[PIN_K])
      next_st.stop_k = STOP_RST;
    else if (st.stop_k != STOP_W'(STOP_CYCLES))
      next_st.stop_k = st.stop_k + STOP_W'(1);
    if (st.p_s2[PIN_KN] != st.p_s3[PIN_KN])
      next_st.stop_kn = STOP_RST;
    else if (st.stop_kn != STOP_W'(STOP_CYCLES))
      next_st.stop_kn = st.stop_kn + STOP_W'(1);
    next_st.locked = st.locked & st.p_s2[PIN_OFF];
    if (dll_reset)
    begin
      next_st.lock_cnt = LOCK_RST;
      next_st.ready = 1'b0;
      next_st.locked = 1'b0;
    end
    else if (!st.ready && k_rise)
    begin
      next_st.lock_cnt = st.lock_cnt + LOCK_W'(1);
      if (st.lock_cnt == LOCK_W'(LOCK_CYCLES - 1))
      begin
        next_st.ready = 1'b1;
        next_st.locked = st.p_s2[PIN_OFF];
      end
    end
    // Late write: first beat on the fourth input-clock rise after t
    if (k_rise)
      next_st.wr_pipe = {st.wr_pipe[WR_DELAY-2:0], {cmd_wr, st.addr_s2}};
    if (beat1)
    begin
      next_st.wr_b2 = 1'b1;
      next_st.wr_addr = st.wr_pipe[WR_DELAY-1].addr;
    end
    else if (beat2)
      next_st.wr_b2 = 1'b0;
    // Writes cannot be stalled at the pins, so a full buffer is flagged
    if (fifo_in_valid && !fifo_in_ready)
      next_st.overrun = 1'b1;
    // Read fetch: both beats land in the slot before the first beat is due
    if (cmd_rd)
    begin
      next_st.fetch = 2'h1;
      next_st.fetch_addr = st.addr_s2;
      next_st.slot_valid = 1'b0;
    end
    else if (st.fetch == 2'h1)
    begin
      next_st.fetch = 2'h2;
      next_st.slot_b1 = mem_rdata;
    end
    else if (st.fetch == 2'h2)
    begin
      next_st.fetch = 2'h0;
      next_st.slot_b2 = mem_rdata;
      next_st.slot_valid = 1'b1;
    end
    // Output drive; no edges means no change on the bus
    case (st.ostate)
      OUT_IDLE, OUT_TAIL:
      begin
        if (st.slot_valid && st.fetch == 2'h0)
        begin
          next_st.act_b1 = st.slot_b1;
          next_st.act_b2 = st.slot_b2;
          next_st.slot_valid = 1'b0;
          next_st.ostate = st.locked ? OUT_ARM : OUT_BEAT1;
        end
        else if (st.ostate == OUT_TAIL && b1_edge)
        begin
          next_st.dq_oe_n = 1'b1;
          next_st.ostate = OUT_IDLE;
        end
      end
      OUT_ARM:
        if (k_rise)
          next_st.ostate = OUT_BEAT1;
      OUT_BEAT1:
        if (b1_edge)
        begin
          next_st.dq_out = st.act_b1;
          next_st.dq_oe_n = 1'b0;
          next_st.ostate = OUT_BEAT2;
        end
      OUT_BEAT2:
        if (b2_edge)
        begin
          next_st.dq_out = st.act_b2;
          next_st.ostate = OUT_TAIL;
        end
      default:
        next_st.ostate = OUT_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st <= '0;
      st.ostate <= OUT_IDLE;
      st.dq_out <= DQ_RST;
      st.dq_oe_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign dq_out = st.dq_out;
  assign dq_oe_n_out = st.dq_oe_n;
  assign ready_out = st.ready;
  assign dll_locked_out = st.locked;
  assign overrun_out = st.overrun;

  bsram_fifo #(.W(WR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(~mem_rd),
    .out_data_out(fifo_out)
  );

  bsram_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .en_in(mem_en),
    .we_in(~mem_rd),
    .addr_in(mem_addr),
    .wdata_in(fifo_out.data),
    .rdata_out(mem_rdata)
  );

  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  lock_count_a:
  assert property ($rose(st.ready) |-> $past(st.lock_cnt) == 12'h7ff)
    else $error("ready rose before 2048 clock cycles");
  not_ready_a:
  assert property (k_rise && !st.ready |=> !st.wr_pipe[0].valid
                   && st.fetch == 2'h0)
    else $error("command taken before lock period ended");
  off_reset_a:
  assert property (off_rise |=> !st.ready && st.lock_cnt == LOCK_RST)
    else $error("disable release did not reset the loop");
  stop_reset_a:
  assert property ($rose(st.stop_k == STOP_W'(STOP_CYCLES)) |-> !st.ready)
    else $error("static clock did not reset the loop");
  disabled_lock_a:
  assert property (st.locked |-> $past(st.p_s2[PIN_OFF]))
    else $error("loop shown locked while disabled");
  burst_addr_a:
  assert property (cmd_rd |=> mem_addr[0] != $past(st.addr_s2[0])
                   && mem_addr[ADDR_W-1:1] == $past(st.addr_s2[ADDR_W-1:1]))
    else $error("second beat address wrong");
  read_start_a:
  assert property (cmd_rd |-> ##3 st.slot_valid)
    else $error("read burst not fetched");
  write_start_a:
  assert property (cmd_wr |=> st.wr_pipe[0].valid
                   && st.wr_pipe[0].addr == $past(st.addr_s2))
    else $error("write burst not started");
  beat1_drive_a:
  assert property (st.ostate == OUT_BEAT1 && b1_edge |=> !st.dq_oe_n
                   && st.dq_out == $past(st.act_b1)
                   && st.ostate == OUT_BEAT2)
    else $error("first read beat not driven");
  burst_hold_a:
  assert property (st.ostate == OUT_BEAT2 && !b2_edge |=> !st.dq_oe_n)
    else $error("read burst cut short");
  stopped_bus_a:
  assert property (!(k_rise || kn_rise || c_rise || cn_rise)
                   |=> $stable(st.dq_oe_n) && $stable(st.dq_out))
    else $error("bus changed while clocks stopped");
endmodule : bsram_core
`default_nettype wire

// >>> bsram_ctrl_model.sv
// Memory controller model: drives the clock pairs, commands and write data.
// The bench may call issue() before the core reports ready; the core ignores such commands.
`timescale 1ns/1ps
`default_nettype none
module bsram_ctrl_model #(
  parameter int HALF = 4
) (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic one_clk_in,
  output logic k_out,
  output logic k_n_out,
  output logic c_out,
  output logic c_n_out,
  output logic load_strobe_n_out,
  output logic rw_sel_out,
  output logic [bsram_pkg::ADDR_W-1:0] addr_out,
  output logic [bsram_pkg::DATA_W-1:0] dq_out,
  output logic [15:0] k_count_out
);
  import bsram_pkg::*;
  int sub = 0;

  // Every pin starts at a defined level, clocks included
  initial
  begin
    k_out = 1'b0;
    load_strobe_n_out = 1'b1;
    rw_sel_out = 1'b0;
    addr_out = '0;
    dq_out = '0;
    k_count_out = 16'h0000;
  end

  assign k_n_out = ~k_out;
  // Tied high in single-clock mode so the input pair times the read data
  assign c_out = one_clk_in | k_out;
  assign c_n_out = one_clk_in | ~k_out;

  // Clocks stand still while run_in is low, which the core takes as a stop
  always @(posedge clk_in)
  begin
    if (run_in)
    begin
      if (sub == HALF - 1)
      begin
        sub <= 0;
        k_out <= ~k_out;
        if (!k_out)
          k_count_out <= k_count_out + 16'h0001;
      end
      else
        sub <= sub + 1;
    end
  end

  task automatic drive_wr(input logic [DATA_W-1:0] b1,
                          input logic [DATA_W-1:0] b2);
    repeat (4) @(posedge k_n_out);
    dq_out <= b1;
    // Data changes mid half period so it stands across each sampling rise
    @(posedge k_out);
    repeat (HALF / 2) @(posedge clk_in);
    dq_out <= b2;
    @(posedge k_n_out);
    repeat (HALF / 2) @(posedge clk_in);
    // Released bus shows the inverse so stale data never passes
    dq_out <= ~b2;
  endtask : drive_wr

  task automatic issue(input logic rd, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] b1,
                       input logic [DATA_W-1:0] b2);
    @(posedge k_n_out);
    load_strobe_n_out <= 1'b0;
    rw_sel_out <= rd;
    addr_out <= a;
    @(posedge k_out);
    if (!rd)
      fork
        drive_wr(b1, b2);
      join_none
    @(posedge k_n_out);
    load_strobe_n_out <= 1'b1;
    rw_sel_out <= 1'($urandom);
    addr_out <= ADDR_W'($urandom);
  endtask : issue
endmodule : bsram_ctrl_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the burst-of-two SRAM core.
// Assumes the controller model file and the design package compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("mismatch at %0t: %s", $time, msg); \
    end \
  end
module tb_top;
  import bsram_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic run = 1'b0;
  logic one_clk = 1'b0;
  logic loop_off = 1'b0;
  logic dll_off_n = 1'b1;
  int fail_count = 0;
  int comparisons = 0;
  logic k, k_n, c, c_n, ld_n, rw, oe_n, ready, locked, overrun;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_wr, dq_rd, d0;
  logic [15:0] kcnt;
  logic [DATA_W-1:0] shadow [0:(1<<ADDR_W)-1];
  int b;
  wire logic tc = one_clk ? k : c;
  wire logic tcn = one_clk ? k_n : c_n;

  always #20 clk_in = ~clk_in;

  bsram_core #(.STOP_CYCLES(16)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .k_in(k), .k_n_in(k_n), .c_in(c), .c_n_in(c_n),
    .dll_off_n_in(dll_off_n), .load_strobe_n_in(ld_n), .rw_sel_in(rw),
    .addr_in(addr), .dq_in(dq_wr), .dq_out(dq_rd), .dq_oe_n_out(oe_n),
    .ready_out(ready), .dll_locked_out(locked), .overrun_out(overrun));

  bsram_ctrl_model #(.HALF(4)) ctrl_u (.clk_in(clk_in), .run_in(run),
    .one_clk_in(one_clk), .k_out(k), .k_n_out(k_n), .c_out(c),
    .c_n_out(c_n), .load_strobe_n_out(ld_n), .rw_sel_out(rw),
    .addr_out(addr), .dq_out(dq_wr), .k_count_out(kcnt));

  task automatic settle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : settle

  task automatic end_test(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : end_test

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic lock_chk(input int base);
    wait (kcnt == base + 2047);
    settle(6);
    `CHK(ready, 1'b0, "ready before lock period")
    wait (kcnt == base + 2048);
    settle(6);
    `CHK(ready, 1'b1, "not ready after lock period")
    `CHK(locked, dll_off_n, "lock flag")
  endtask : lock_chk

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input bit last);
    logic [DATA_W-1:0] e1;
    logic [DATA_W-1:0] e2;
    e1 = shadow[a];
    e2 = shadow[{a[ADDR_W-1:1], ~a[0]}];
    // Step off the edge that ended the command before watching clocks
    settle(1);
    // Each beat is looked at just before the next pin edge can move it
    if (loop_off)
      @(posedge tc);
    else
      @(posedge tcn);
    settle(4);
    `CHK(dq_rd, e1, "first beat")
    `CHK(oe_n, 1'b0, "bus not driven")
    if (loop_off)
      @(posedge tcn);
    else
      @(posedge tc);
    settle(4);
    `CHK(dq_rd, e2, "second beat")
    if (last)
    begin
      if (loop_off)
        @(posedge tc);
      else
        @(posedge tcn);
      settle(4);
      `CHK(oe_n, 1'b1, "bus not released")
    end
  endtask : chk_rd

  task automatic traffic(input string s, input int n);
    logic [ADDR_W-1:0] a [0:7];
    logic [DATA_W-1:0] b1;
    logic [DATA_W-1:0] b2;
    for (int i = 0; i < n; i++)
    begin
      a[i] = (i == 0) ? '0 : (i == 1) ? '1 : ADDR_W'($urandom);
      b1 = DATA_W'($urandom);
      b2 = DATA_W'($urandom);
      ctrl_u.issue(1'b0, a[i], b1, b2);
      shadow[a[i]] = b1;
      shadow[{a[i][ADDR_W-1:1], ~a[i][0]}] = b2;
    end
    // Idle cycles carry random address and select with the strobe high
    repeat (24) @(posedge k);
    settle(1);
    `CHK(oe_n, 1'b1, "bus driven on no-op")
    for (int i = 0; i < n; i++)
    begin
      ctrl_u.issue(1'b1, a[i], '0, '0);
      fork
        automatic int j = i;
        chk_rd(a[j], j == n - 1);
      join_none
    end
    repeat (6) @(posedge k);
    `CHK(overrun, 1'b0, "write buffer overrun")
    end_test(s);
  endtask : traffic

  initial
  begin
    #(80000 * 40);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict;
  end

  initial
  begin
    void'($urandom(32'h134e));
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    settle(1);
    `CHK(oe_n, 1'b1, "reset enable")
    `CHK(ready, 1'b0, "reset ready")
    `CHK(locked, 1'b0, "reset lock")
    `CHK(overrun, 1'b0, "reset overrun")
    `CHK(dq_rd, DQ_RST, "reset data")
    end_test("reset");
    b = kcnt;
    repeat (4) @(posedge clk_in);
    run <= 1'b1;
    // Read inside the lock period must be ignored
    ctrl_u.issue(1'b1, 8'h10, '0, '0);
    settle(60);
    `CHK(oe_n, 1'b1, "read taken before ready")
    // Commands only after the full lock period
    lock_chk(b);
    traffic("locked", 8);
    // Stop only with every burst finished
    d0 = dq_rd;
    @(posedge clk_in);
    run <= 1'b0;
    settle(30);
    `CHK(ready, 1'b0, "ready kept over stop")
    `CHK(dq_rd, d0, "data changed over stop")
    `CHK(oe_n, 1'b1, "enable changed over stop")
    // Count from the stop: a toggle on the stopping edge is not relocking
    b = kcnt;
    @(posedge clk_in);
    run <= 1'b1;
    lock_chk(b);
    end_test("clock stop");
    @(posedge clk_in);
    one_clk <= 1'b1;
    traffic("single clock", 4);
    @(posedge clk_in);
    one_clk <= 1'b0;
    dll_off_n <= 1'b0;
    settle(8);
    `CHK(ready, 1'b1, "falling disable reset loop")
    @(posedge clk_in);
    dll_off_n <= 1'b1;
    settle(6);
    `CHK(ready, 1'b0, "rising disable kept ready")
    end_test("disable edge");
    @(posedge clk_in);
    nrst_in <= 1'b0;
    run <= 1'b0;
    dll_off_n <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    b = kcnt;
    repeat (4) @(posedge clk_in);
    run <= 1'b1;
    lock_chk(b);
    loop_off = 1'b1;
    traffic("loop off", 6);
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
